// *** pwmco_channel.sv ***
// single pwm channel with output control, irq logic and axi4-lite register slave
`timescale 1ns/10ps
`default_nettype none
// Function
// - with output enable low the pin is not driven and the channel only raises interrupts.
// - the align select bit picks edge aligned (0) or center aligned (1) waveforms.
// - the single shot bit at 1 makes the channel run single shot instead of free running.
// - with the channel irq enable set, the channel flag sets on each shadow load.
// - with the module irq enable set, the module flag sets on each fresh enabled channel request, not while a channel flag stays set.
// - channel flags stay set on service entry and only software clears them.
// - the module flag clears on service entry whatever channel requests are pending.
// - a channel request during service sets the module flag again.
// - the waveform leaves on port 7 bit 3, gated by the output enable bit.
// - the waveform is xored with the port latch bit before reaching the pin.
// - the waveform is high while the counter is at or above the shadow width.
// - the shadow loads from the width register each cycle start or on a stopped write.
// - a period match resets the counter or turns it to count down.
// - the counter only advances while its run bit is set.
module pwmco_channel
  import pwmco_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic isr_entry_i,
  output logic p7_3_o,
  output logic p7_3_oe_o,
  output logic module_irq_o,
  output logic irq_o
);
  if (WIDTH != 16) begin : g_bad_width
    $error("pwmco_channel: register layout assumes WIDTH 16");
  end

  typedef struct packed {
    logic out_en;
    logic align;
    logic shot;
    logic run;
    logic ch_ie;
    logic ch_ir;
    logic mod_ie;
    logic mod_ir;
    logic latch;
    logic [15:0] period;
    logic [15:0] width;
    logic [PWMCO_EV_NUM-1:0] ev_stat;
    logic [PWMCO_EV_NUM-1:0] ev_mask;
    logic aw_got;
    logic w_got;
    logic [15:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic pin;
    logic pin_oe;
    logic irq;
    logic mod_irq;
  } pwmco_state_t;

  pwmco_state_t st;
  pwmco_state_t next_st;

  logic [15:0] count;
  logic wave;
  logic load;
  logic period_end;
  logic wr_go;
  logic width_wr;
  logic cnt_wr;
  logic [15:0] wd16;
  logic [15:0] rd16;
  logic rd_ok;
  logic ch_req;

  // ----------------------------------------
  // counter core
  // ----------------------------------------
  pwmco_counter #(
    .WIDTH(WIDTH)
  ) u_counter (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .run_i(st.run),
    .center_i(st.align),
    .period_i(st.period),
    .width_i(next_st.width),
    .width_wr_i(width_wr),
    .cnt_wr_i(cnt_wr),
    .cnt_wdata_i(wd16),
    .count_o(count),
    .wave_o(wave),
    .load_o(load),
    .period_end_o(period_end)
  );

  assign wr_go = st.aw_got && st.w_got && !st.bvalid;
  assign width_wr = wr_go && st.awaddr == PWMCO_WIDTH_OFS;
  assign cnt_wr = wr_go && st.awaddr == PWMCO_COUNTER_OFS;
  // only the low two byte lanes carry register data
  assign wd16 = {st.wstrb[1] ? st.wdata[15:8] : 8'h00, st.wstrb[0] ? st.wdata[7:0] : 8'h00};

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rd16 = 16'h0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      PWMCO_MODE_CTRL_OFS: begin
        rd16[PWMCO_OUT_EN_BIT] = st.out_en;
        rd16[PWMCO_ALIGN_BIT] = st.align;
        rd16[PWMCO_SHOT_BIT] = st.shot;
      end
      PWMCO_TIMER_CTRL_OFS: begin
        rd16[PWMCO_RUN_BIT] = st.run;
        rd16[PWMCO_CH_IE_BIT] = st.ch_ie;
        rd16[PWMCO_CH_IR_BIT] = st.ch_ir;
      end
      PWMCO_PERIOD_OFS: rd16 = st.period;
      PWMCO_WIDTH_OFS: rd16 = st.width;
      PWMCO_COUNTER_OFS: rd16 = count;
      PWMCO_MODIRQ_OFS: begin
        rd16[PWMCO_MOD_IE_BIT] = st.mod_ie;
        rd16[PWMCO_MOD_IR_BIT] = st.mod_ir;
      end
      PWMCO_PORT_LATCH_OFS: rd16[0] = st.latch;
      PWMCO_IRQ_STATUS_OFS: rd16[PWMCO_EV_NUM-1:0] = st.ev_stat;
      PWMCO_IRQ_MASK_OFS: rd16[PWMCO_EV_NUM-1:0] = st.ev_mask;
      default: rd_ok = 1'b0;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;

    // ----------------------------------------
    // bus handshakes
    // ----------------------------------------
    // address and data may arrive in either order
    if (s_axi_awvalid && !st.aw_got) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_got) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = {16'h0000, rd16};
      next_st.rresp = rd_ok ? PWMCO_RESP_OKAY : PWMCO_RESP_SLVERR;
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    // clears come first so a same-cycle hardware set wins
    if (wr_go) begin
      next_st.bvalid = 1'b1;
      next_st.bresp = PWMCO_RESP_OKAY;
      case (st.awaddr)
        PWMCO_MODE_CTRL_OFS: begin
          next_st.out_en = wd16[PWMCO_OUT_EN_BIT];
          next_st.align = wd16[PWMCO_ALIGN_BIT];
          next_st.shot = wd16[PWMCO_SHOT_BIT];
        end
        PWMCO_TIMER_CTRL_OFS: begin
          next_st.run = wd16[PWMCO_RUN_BIT];
          next_st.ch_ie = wd16[PWMCO_CH_IE_BIT];
          next_st.ch_ir = wd16[PWMCO_CH_IR_BIT];
        end
        PWMCO_PERIOD_OFS: next_st.period = wd16;
        PWMCO_WIDTH_OFS: next_st.width = wd16;
        PWMCO_COUNTER_OFS: next_st.period = st.period;
        PWMCO_MODIRQ_OFS: begin
          next_st.mod_ie = wd16[PWMCO_MOD_IE_BIT];
          next_st.mod_ir = wd16[PWMCO_MOD_IR_BIT];
        end
        PWMCO_PORT_LATCH_OFS: next_st.latch = wd16[0];
        PWMCO_IRQ_STATUS_OFS: next_st.ev_stat = st.ev_stat & ~wd16[PWMCO_EV_NUM-1:0];
        PWMCO_IRQ_MASK_OFS: next_st.ev_mask = wd16[PWMCO_EV_NUM-1:0];
        default: next_st.bresp = PWMCO_RESP_SLVERR;
      endcase
    end

    // ----------------------------------------
    // interrupt flags
    // ----------------------------------------
    // service entry drops the module flag; channel flag is left alone
    if (isr_entry_i) begin
      next_st.mod_ir = 1'b0;
    end

    // ----------------------------------------
    // single shot, channel and module flag sets, sticky events
    // ----------------------------------------
    // one cycle then stop, counter parks below the width
    if (st.shot && st.run && period_end && !st.align) begin
      next_st.run = 1'b0;
    end
    if (st.shot && st.run && load && st.align) begin
      next_st.run = 1'b0;
    end
    if (st.ch_ie && load) begin
      next_st.ch_ir = 1'b1;
    end
    // fresh requests only: a flag left pending must not undo the service-entry clear
    ch_req = st.ch_ie && load;
    if (st.mod_ie && ch_req) begin
      next_st.mod_ir = 1'b1;
    end
    next_st.ev_stat[PWMCO_EV_SHADOW] = next_st.ev_stat[PWMCO_EV_SHADOW] | load;
    next_st.ev_stat[PWMCO_EV_PERIOD] = next_st.ev_stat[PWMCO_EV_PERIOD] | period_end;
    next_st.ev_stat[PWMCO_EV_SHOT_DONE] = next_st.ev_stat[PWMCO_EV_SHOT_DONE]
      | (st.run && !next_st.run && st.shot);

    // ----------------------------------------
    // events, pin and readies
    // ----------------------------------------
    // pin: xor with latch, driven only with output enable
    next_st.pin_oe = next_st.out_en;
    next_st.pin = next_st.out_en && ((wave && st.run) ^ next_st.latch);
    next_st.irq = |(next_st.ev_stat & next_st.ev_mask);
    next_st.mod_irq = next_st.mod_ir;
    // readies are registered so no top output passes through a gate
    next_st.aw_rdy = !next_st.aw_got;
    next_st.w_rdy = !next_st.w_got;
    next_st.ar_rdy = !next_st.rvalid;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
      // readies come up high so the first request is taken at once
      st.aw_rdy <= 1'b1;
      st.w_rdy <= 1'b1;
      st.ar_rdy <= 1'b1;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs are fields of the state register
  // ----------------------------------------
  assign s_axi_awready = st.aw_rdy;
  assign s_axi_wready = st.w_rdy;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.ar_rdy;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign p7_3_o = st.pin;
  assign p7_3_oe_o = st.pin_oe;
  assign module_irq_o = st.mod_irq;
  assign irq_o = st.irq;
endmodule
`default_nettype wire

// *** pwmco_pkg.sv ***
// package: register map, field positions and reset values of the pwm channel
package pwmco_pkg;
  // register byte addresses; the printed offsets are word aligned
  localparam logic [15:0] PWMCO_MODE_CTRL_OFS = 16'hFF32;
  localparam logic [15:0] PWMCO_TIMER_CTRL_OFS = 16'hFF30;
  localparam logic [15:0] PWMCO_PERIOD_OFS = 16'hFF34;
  localparam logic [15:0] PWMCO_WIDTH_OFS = 16'hFF36;
  localparam logic [15:0] PWMCO_COUNTER_OFS = 16'hFF38;
  localparam logic [15:0] PWMCO_MODIRQ_OFS = 16'hFF3C;
  localparam logic [15:0] PWMCO_PORT_LATCH_OFS = 16'hFF40;
  localparam logic [15:0] PWMCO_IRQ_STATUS_OFS = 16'hFF44;
  localparam logic [15:0] PWMCO_IRQ_MASK_OFS = 16'hFF48;
  // mode and output control fields
  localparam int PWMCO_OUT_EN_BIT = 0;
  localparam int PWMCO_ALIGN_BIT = 4;
  localparam int PWMCO_SHOT_BIT = 15;
  // timer and channel irq control fields
  localparam int PWMCO_RUN_BIT = 3;
  localparam int PWMCO_CH_IE_BIT = 11;
  localparam int PWMCO_CH_IR_BIT = 15;
  // module irq control fields
  localparam int PWMCO_MOD_IE_BIT = 6;
  localparam int PWMCO_MOD_IR_BIT = 7;
  // reset values
  localparam logic [15:0] PWMCO_CTRL_RST = 16'h0000;
  localparam logic [15:0] PWMCO_COUNT_RST = 16'h0000;
  // status bits of the sticky event register
  localparam int PWMCO_EV_SHADOW = 0;
  localparam int PWMCO_EV_PERIOD = 1;
  localparam int PWMCO_EV_SHOT_DONE = 2;
  localparam int PWMCO_EV_NUM = 3;
  // axi response codes
  localparam logic [1:0] PWMCO_RESP_OKAY = 2'h0;
  localparam logic [1:0] PWMCO_RESP_SLVERR = 2'h2;
endpackage

// *** pwmco_counter.sv ***
// counter, shadow compare and waveform generator of the pwm channel
`timescale 1ns/10ps
`default_nettype none
module pwmco_counter
  import pwmco_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic run_i,
  input wire logic center_i,
  input wire logic [WIDTH-1:0] period_i,
  input wire logic [WIDTH-1:0] width_i,
  input wire logic width_wr_i,
  input wire logic cnt_wr_i,
  input wire logic [WIDTH-1:0] cnt_wdata_i,
  output logic [WIDTH-1:0] count_o,
  output logic wave_o,
  output logic load_o,
  output logic period_end_o
);
  if (WIDTH < 2 || WIDTH > 16) begin : g_bad_width
    $error("pwmco_counter: WIDTH must be 2..16");
  end

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic [WIDTH-1:0] shadow;
    logic down;
    logic wave;
    logic load;
    logic pend;
  } pwmco_cnt_state_t;

  localparam logic [WIDTH-1:0] COUNT_RST_W = PWMCO_COUNT_RST[WIDTH-1:0];

  pwmco_cnt_state_t st;
  pwmco_cnt_state_t next_st;

  // ----------------------------------------
  // counting and compare
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.load = 1'b0;
    next_st.pend = 1'b0;
    if (cnt_wr_i) begin
      next_st.cnt = cnt_wdata_i;
    end else if (run_i) begin
      // a period match on the down slope is ignored, else a late period write stalls the count
      if (st.cnt == period_i && !st.down) begin
        next_st.pend = 1'b1;
        if (center_i && !st.down) begin
          next_st.down = 1'b1;
          next_st.cnt = st.cnt - WIDTH'(1);
        end else if (!center_i) begin
          next_st.cnt = COUNT_RST_W;
          next_st.shadow = width_i;
          next_st.load = 1'b1;
        end
      end else if (st.down) begin
        if (st.cnt == '0) begin
          // center aligned cycle restarts at zero
          next_st.down = 1'b0;
          next_st.cnt = WIDTH'(1);
          next_st.shadow = width_i;
          next_st.load = 1'b1;
        end else begin
          next_st.cnt = st.cnt - WIDTH'(1);
        end
      end else begin
        next_st.cnt = st.cnt + WIDTH'(1);
      end
    end else if (width_wr_i) begin
      // stopped counter: software write goes straight through
      next_st.shadow = width_i;
      next_st.load = 1'b1;
    end
    next_st.wave = (next_st.cnt >= next_st.shadow);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  assign count_o = st.cnt;
  assign wave_o = st.wave;
  assign load_o = st.load;
  assign period_end_o = st.pend;
endmodule
`default_nettype wire

// *** pwmco_intc_model.sv ***
// far side model: interrupt controller entry and pin load with pull-down
`timescale 1ns/10ps
`default_nettype none
module pwmco_intc_model (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic irq_i,
  input wire logic ack_en_i,
  input wire logic p7_3_i,
  input wire logic p7_3_oe_i,
  output logic isr_entry_o,
  output logic pin_o
);
  logic busy;
  // one entry per request; re-armed only once the request drops
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      isr_entry_o <= 1'b0;
      busy <= 1'b0;
    end else begin
      isr_entry_o <= irq_i && ack_en_i && !busy && !isr_entry_o;
      if (irq_i && ack_en_i && !busy) begin
        busy <= 1'b1;
      end else if (!irq_i) begin
        busy <= 1'b0;
      end
    end
  end
  // undriven pin falls to the pull-down level
  assign pin_o = p7_3_oe_i ? p7_3_i : 1'b0;
endmodule
`default_nettype wire

// *** pwmco_channel_checker.sv ***
// assertion checker bound to the pwm channel ports
`timescale 1ns/10ps
`default_nettype none
module pwmco_channel_checker (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic isr_entry_i,
  input wire logic p7_3_o,
  input wire logic p7_3_oe_o,
  input wire logic module_irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_pin_quiet: assert property (!p7_3_oe_o |-> !p7_3_o)
    else $error("pin high while output disabled");
  a_oe_by_write: assert property ($changed(p7_3_oe_o) |-> s_axi_bvalid)
    else $error("output enable moved without a write");
  a_mod_flag_fall: assert property ($fell(module_irq_o) |-> $past(isr_entry_i)
    || s_axi_bvalid) else $error("module flag fell alone");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_w_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  c_irq: cover property ($rose(module_irq_o));
  c_entry: cover property (isr_entry_i && module_irq_o);
  c_pin: cover property (p7_3_oe_o && p7_3_o);
endmodule
bind pwmco_channel pwmco_channel_checker u_chk (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .isr_entry_i(isr_entry_i),
  .p7_3_o(p7_3_o), .p7_3_oe_o(p7_3_oe_o), .module_irq_o(module_irq_o));
`default_nettype wire

// *** pwmco_channel_tb.sv ***
// self-checking testbench of the pwm channel
`timescale 1ns/10ps
`default_nettype none
module pwmco_channel_tb
  import pwmco_pkg::*;
;
  logic clk, rst_n, awv, awr, wv, wr_, bv, arv, arr, rv, isr, p7, oe, mirq, irq, pin;
  logic ack_en;
  logic [15:0] awa, ara;
  logic [31:0] wd, rdt, d;
  logic [1:0] bresp, rresp;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  pwmco_channel dut (.core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .isr_entry_i(isr), .p7_3_o(p7), .p7_3_oe_o(oe),
    .module_irq_o(mirq), .irq_o(irq));
  pwmco_intc_model u_far (.core_clk_i(clk), .rst_n_i(rst_n), .irq_i(mirq),
    .ack_en_i(ack_en), .p7_3_i(p7), .p7_3_oe_i(oe), .isr_entry_o(isr), .pin_o(pin));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bready and rready stay high, so every answer is taken at once
  task automatic wr(input logic [15:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_) wv <= 1'b0;
    end while (!bv);
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e, input string nm,
    input logic [1:0] er = 2'h0);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    d = rdt;
    chk("rresp", er, rresp);
    chk(nm, e, d);
  endtask
  task automatic wt(ref logic s, input logic v, input string nm);
    repeat (100) begin
      @(posedge clk);
      if (s === v) break;
    end
    chk(nm, v, s);
  endtask
  task automatic duty(input int n, input int e, input string nm);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge clk);
      if (pin === 1'b1) c++;
    end
    chk(nm, e, c);
  endtask
  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ceiling well above the roughly 300 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0; awv = 1'b0; wv = 1'b0; arv = 1'b0; ack_en = 1'b0;
    awa = 16'h0000; ara = 16'h0000; wd = 32'h00000000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(PWMCO_MODE_CTRL_OFS, 32'h00000000, "mode reset");
    rd(PWMCO_TIMER_CTRL_OFS, 32'h00000000, "timer reset");
    rd(16'hFFF0, 32'h00000000, "unmapped", 2'h2);
    wr(16'hFFF0, 32'h0000FFFF, 2'h2);
    wr(PWMCO_MODE_CTRL_OFS, 32'h0000FFFF);
    rd(PWMCO_MODE_CTRL_OFS, 32'h00008011, "mode bits");
    wr(PWMCO_MODE_CTRL_OFS, 32'h00000000);
    $display("test regs done");
    wr(PWMCO_PORT_LATCH_OFS, 32'h00000001);
    repeat (2) @(posedge clk);
    chk("oe off", 1'b0, oe);
    wr(PWMCO_MODE_CTRL_OFS, 32'h00000001);
    repeat (2) @(posedge clk);
    chk("oe on", 1'b1, oe);
    chk("pin inverted", 1'b1, pin);
    wr(PWMCO_PORT_LATCH_OFS, 32'h00000000);
    wr(PWMCO_PERIOD_OFS, 32'h00000003);
    wr(PWMCO_WIDTH_OFS, 32'h00000003);
    wr(PWMCO_TIMER_CTRL_OFS, 32'h00000008);
    duty(40, 10, "edge duty");
    wr(PWMCO_TIMER_CTRL_OFS, 32'h00000000);
    // stop lands two edges after the last duty sample, on the period value
    rd(PWMCO_COUNTER_OFS, 32'h00000003, "count", 2'h0);
    rd(PWMCO_COUNTER_OFS, d, "stopped count");
    $display("test edge done");
    wr(PWMCO_COUNTER_OFS, 32'h00000000);
    wr(PWMCO_MODE_CTRL_OFS, 32'h00000011);
    wr(PWMCO_PORT_LATCH_OFS, 32'h00000001);
    wr(PWMCO_TIMER_CTRL_OFS, 32'h00000008);
    duty(60, 50, "center duty");
    wr(PWMCO_TIMER_CTRL_OFS, 32'h00000000);
    wr(PWMCO_PORT_LATCH_OFS, 32'h00000000);
    $display("test center done");
    wr(PWMCO_IRQ_MASK_OFS, 32'h00000001);
    wr(PWMCO_MODIRQ_OFS, 32'h00000040);
    wr(PWMCO_TIMER_CTRL_OFS, 32'h00000808);
    wt(mirq, 1'b1, "module flag set");
    wt(irq, 1'b1, "event irq");
    wr(PWMCO_TIMER_CTRL_OFS, 32'h00008800);
    rd(PWMCO_TIMER_CTRL_OFS, 32'h00008800, "channel flag");
    ack_en <= 1'b1;
    wt(mirq, 1'b0, "entry clears");
    ack_en <= 1'b0;
    rd(PWMCO_TIMER_CTRL_OFS, 32'h00008800, "flag kept");
    wr(PWMCO_TIMER_CTRL_OFS, 32'h00000800);
    rd(PWMCO_TIMER_CTRL_OFS, 32'h00000800, "flag cleared");
    wr(PWMCO_IRQ_MASK_OFS, 32'h00000000);
    wt(irq, 1'b0, "masked");
    wr(PWMCO_IRQ_MASK_OFS, 32'h00000001);
    wt(irq, 1'b1, "unmasked");
    rd(PWMCO_IRQ_STATUS_OFS, 32'h00000003, "status");
    wr(PWMCO_IRQ_STATUS_OFS, 32'h00000007);
    wt(irq, 1'b0, "status cleared");
    wr(PWMCO_TIMER_CTRL_OFS, 32'h00000808);
    wt(mirq, 1'b1, "flag again");
    $display("test irq done");
    wr(PWMCO_TIMER_CTRL_OFS, 32'h00000000);
    wr(PWMCO_COUNTER_OFS, 32'h00000000);
    // a load in the stopping cycle may set the channel flag again
    wr(PWMCO_TIMER_CTRL_OFS, 32'h00000000);
    wr(PWMCO_MODE_CTRL_OFS, 32'h00008001);
    wr(PWMCO_TIMER_CTRL_OFS, 32'h00000008);
    repeat (20) @(posedge clk);
    rd(PWMCO_TIMER_CTRL_OFS, 32'h00000000, "run cleared");
    rd(PWMCO_IRQ_STATUS_OFS, 32'h00000007, "shot status");
    chk("shot done", 1'b1, d[2]);
    chk("pin idle", 1'b0, pin);
    $display("test single shot done");
    end_sim();
  end
endmodule
`default_nettype wire
